// ==== verilog/sodr_pkg.sv ====
// Purpose: shared constants and types of the system options and debug reset bank
// Assumes: 8-bit register port with a 3-bit register index
// Notes:   register indices are local choices; field positions follow the register layouts
`default_nettype none

package sodr_pkg;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef logic [2:0] sodr_addr_t;
    typedef logic [7:0] sodr_byte_t;

    // ------------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------------
    localparam sodr_addr_t ADDR_DEBUG_FORCE_RESET    = 3'h0;
    localparam sodr_addr_t ADDR_SYSTEM_OPTIONS_ONCE  = 3'h1;
    localparam sodr_addr_t ADDR_CLOCK_OUTPUT_CONTROL = 3'h2;
    localparam sodr_addr_t ADDR_PART_ID_HIGH         = 3'h3;
    localparam sodr_addr_t ADDR_PART_ID_LOW          = 3'h4;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int FORCE_RESET_BIT_POS         = 0;
    localparam int WATCHDOG_ENABLE_POS         = 7;
    localparam int WATCHDOG_LONG_TIMEOUT_POS   = 6;
    localparam int STOP_MODE_ALLOW_POS         = 5;
    localparam int CLOCK_OUTPUT_PIN_ENABLE_POS = 4;
    localparam int CLOCK_OUTPUT_DIVIDE_LSB     = 0;
    localparam int CLOCK_OUTPUT_DIVIDE_W       = 3;
    localparam int PART_ID_W                   = 12;

    // ------------------------------------------------------------------
    // masks and reset values
    // ------------------------------------------------------------------
    localparam sodr_byte_t DEBUG_FORCE_RESET_READ = 8'h00;
    localparam sodr_byte_t OPTIONS_IMPL_MASK      = 8'hf3;
    localparam sodr_byte_t OPTIONS_RESET          = 8'hc0;
    localparam sodr_byte_t CLOCK_CTRL_IMPL_MASK   = 8'h17;
    localparam sodr_byte_t CLOCK_CTRL_RESET       = 8'h00;
    localparam sodr_byte_t UNMAPPED_READ          = 8'h00;

endpackage : sodr_pkg

`default_nettype wire

// ==== verilog/sodr_once_reg.sv ====
// Purpose: register that honours only the first write after reset
// Assumes: synchronous active-low reset
// Notes:   locked reads back whether the single write is used up
`default_nettype none

module sodr_once_reg
#(
    parameter int           W   = 8,
    parameter logic [W-1:0] RST = '0
)
(
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    // write side
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wdata,
    // stored value
    output var  logic [W-1:0] q,
    output var  logic         locked
);

    wire take_write = wr_en && !locked;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            q      <= RST;
            locked <= 1'b0;
        end
        else if (take_write)
        begin
            q      <= wdata;
            locked <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    chk_once_lock_holds: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (locked && wr_en) |=> ($stable(q) && locked))
        else $error("write-once register changed after lock");

endmodule // sodr_once_reg

`default_nettype wire

// ==== verilog/sodr_clk_div.sv ====
// Purpose: divided clock output generator, half period of divisor bus cycles
// Assumes: divisor of zero or a disabled output parks the output low
// Notes:   a divisor change restarts the half period count
`default_nettype none

module sodr_clk_div
#(
    parameter int DW = 3
)
(
    // clock and reset
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    // control
    input  wire logic          en,
    input  wire logic [DW-1:0] divisor,
    // divided output
    output var  logic          clk_div
);

    logic [DW-1:0] cnt;
    logic [DW-1:0] prev_divisor;

    wire           run        = en && (divisor != '0);
    wire [DW-1:0]  last_count = divisor - {{(DW-1){1'b0}}, 1'b1};
    wire           changed    = divisor != prev_divisor;
    wire           wrap       = (cnt >= last_count) || changed;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n || !run)
        begin
            cnt     <= '0;
            clk_div <= 1'b0;
        end
        else if (wrap)
        begin
            cnt     <= '0;
            clk_div <= !clk_div;
        end
        else
        begin
            cnt <= cnt + {{(DW-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            prev_divisor <= '0;
        else
            prev_divisor <= divisor;
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // cycles since the last toggle; a parked output counts as a toggle at the park edge
    logic [7:0] run_len;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n || !run)
            run_len <= 8'h00;
        else if ($changed(clk_div))
            run_len <= 8'h01;
        else if (run_len != 8'hff)
            run_len <= run_len + 8'h01;
    end

    chk_half_period_len: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (run && $past(run) && $stable(divisor) && $past(prev_divisor) == divisor
         && $changed(clk_div))
        |-> (run_len == 8'(divisor)))
        else $error("divided clock half period differs from divisor");

endmodule // sodr_clk_div

`default_nettype wire

// ==== verilog/sodr_regs.sv ====
// Purpose: system options, debug force reset, clock output and part id registers
// Assumes: one bus clock core_clk at 10 MHz, synchronous active-low rst_n
// Notes:   read data appear one cycle after the read strobe and hold until the next read
`default_nettype none

module sodr_regs
#(
    // arbitrary value, not tied to any real part
    parameter logic [11:0] PART_ID       = 12'h5a3,
    parameter logic [3:0]  ID_HIGH_RSVD  = 4'h0
)
(
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    // register port
    input  wire sodr_pkg::sodr_addr_t reg_addr,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic                 reg_from_debug,
    input  wire sodr_pkg::sodr_byte_t reg_wdata,
    output var  sodr_pkg::sodr_byte_t reg_rdata,
    // reset control
    output var  logic                 mcu_reset_req,
    output var  logic                 reset_cause_flags_clear,
    // watchdog and stop controls
    output var  logic                 watchdog_enable,
    output var  logic                 watchdog_long_timeout,
    output var  logic                 stop_mode_allow,
    input  wire logic                 stop_exec,
    output var  logic                 stop_enter,
    output var  logic                 illegal_opcode_reset,
    // divided clock output on port c pin two
    output var  logic                 port_c_pin_two,
    output var  logic                 port_c_pin_two_oe
);

    import sodr_pkg::*;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    wire sel_dfr  = reg_addr == ADDR_DEBUG_FORCE_RESET;
    wire sel_opt  = reg_addr == ADDR_SYSTEM_OPTIONS_ONCE;
    wire sel_clk  = reg_addr == ADDR_CLOCK_OUTPUT_CONTROL;
    wire sel_idh  = reg_addr == ADDR_PART_ID_HIGH;
    wire sel_idl  = reg_addr == ADDR_PART_ID_LOW;

    wire wr_dfr   = reg_wr && sel_dfr && reg_from_debug;
    wire wr_opt   = reg_wr && sel_opt;
    wire wr_clk   = reg_wr && sel_clk;
    wire force_hit = wr_dfr && reg_wdata[FORCE_RESET_BIT_POS];

    // ------------------------------------------------------------------
    // system options, write once
    // ------------------------------------------------------------------
    sodr_byte_t opt_q;
    logic       opt_locked;

    sodr_once_reg
    #(
        .W   (8),
        .RST (OPTIONS_RESET)
    )
    u_opt
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wr_en    (wr_opt),
        .wdata    (reg_wdata & OPTIONS_IMPL_MASK),
        .q        (opt_q),
        .locked   (opt_locked)
    );

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            watchdog_enable       <= OPTIONS_RESET[WATCHDOG_ENABLE_POS];
            watchdog_long_timeout <= OPTIONS_RESET[WATCHDOG_LONG_TIMEOUT_POS];
            stop_mode_allow       <= OPTIONS_RESET[STOP_MODE_ALLOW_POS];
        end
        else
        begin
            watchdog_enable       <= opt_q[WATCHDOG_ENABLE_POS];
            watchdog_long_timeout <= opt_q[WATCHDOG_LONG_TIMEOUT_POS];
            stop_mode_allow       <= opt_q[STOP_MODE_ALLOW_POS];
        end
    end

    // ------------------------------------------------------------------
    // stop instruction outcome
    // ------------------------------------------------------------------
    wire next_stop_enter = stop_exec && opt_q[STOP_MODE_ALLOW_POS];
    wire next_illegal    = stop_exec && !opt_q[STOP_MODE_ALLOW_POS];

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            stop_enter           <= 1'b0;
            illegal_opcode_reset <= 1'b0;
        end
        else
        begin
            stop_enter           <= next_stop_enter;
            illegal_opcode_reset <= next_illegal;
        end
    end

    // ------------------------------------------------------------------
    // debug force reset
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            mcu_reset_req           <= 1'b0;
            reset_cause_flags_clear <= 1'b0;
        end
        else
        begin
            mcu_reset_req           <= force_hit;
            reset_cause_flags_clear <= force_hit;
        end
    end

    // ------------------------------------------------------------------
    // clock output control
    // ------------------------------------------------------------------
    sodr_byte_t clk_ctl;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            clk_ctl <= CLOCK_CTRL_RESET;
        else if (wr_clk)
            clk_ctl <= reg_wdata & CLOCK_CTRL_IMPL_MASK;
    end

    wire                             pin_en  = clk_ctl[CLOCK_OUTPUT_PIN_ENABLE_POS];
    wire [CLOCK_OUTPUT_DIVIDE_W-1:0] divide  =
        clk_ctl[CLOCK_OUTPUT_DIVIDE_LSB +: CLOCK_OUTPUT_DIVIDE_W];
    logic                            clk_div;

    sodr_clk_div
    #(
        .DW (CLOCK_OUTPUT_DIVIDE_W)
    )
    u_div
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .en       (pin_en),
        .divisor  (divide),
        .clk_div  (clk_div)
    );

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            port_c_pin_two    <= 1'b0;
            port_c_pin_two_oe <= 1'b0;
        end
        else
        begin
            port_c_pin_two    <= pin_en && clk_div;
            port_c_pin_two_oe <= pin_en;
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    wire sodr_byte_t id_high = {ID_HIGH_RSVD, PART_ID[11:8]};
    wire sodr_byte_t id_low  = PART_ID[7:0];

    wire sodr_byte_t next_rdata =
        sel_dfr ? DEBUG_FORCE_RESET_READ :
        sel_opt ? (opt_q & OPTIONS_IMPL_MASK) :
        sel_clk ? clk_ctl :
        sel_idh ? id_high :
        sel_idl ? id_low : UNMAPPED_READ;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            reg_rdata <= UNMAPPED_READ;
        else if (reg_rd)
            reg_rdata <= next_rdata;
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_debug_force;
        reg_wr && reg_from_debug && sel_dfr && reg_wdata[0];
    endsequence

    // the pulse ends unless another forced reset was taken in its own cycle
    sequence s_reset_pulse;
        (mcu_reset_req && reset_cause_flags_clear) ##1 (mcu_reset_req == $past(force_hit));
    endsequence

    chk_dfr_reads_zero: assert property (
        (reg_rd && sel_dfr) |=> (reg_rdata == 8'h00))
        else $error("debug force reset register read nonzero");

    chk_user_write_ignored: assert property (
        (reg_wr && sel_dfr && !reg_from_debug) |=> !mcu_reset_req)
        else $error("program write to debug force reset acted");

    chk_debug_reset_fires: assert property (
        s_debug_force |=> s_reset_pulse)
        else $error("debug force reset did not request a reset");

    chk_flags_clear_paired: assert property (
        mcu_reset_req == reset_cause_flags_clear)
        else $error("forced reset without cause flag clear");

    chk_opt_write_once: assert property (
        (opt_locked && wr_opt) |=> ##1 ($stable(watchdog_enable)
        && $stable(watchdog_long_timeout) && $stable(stop_mode_allow)))
        else $error("options changed after first write");

    chk_opt_unimpl_zero: assert property (
        (reg_rd && sel_opt) |=> (reg_rdata[3:2] == 2'b00))
        else $error("options unimplemented bits read nonzero");

    chk_opt_reset_vals: assert property (
        !$past(rst_n) |-> (watchdog_enable && watchdog_long_timeout
        && !stop_mode_allow))
        else $error("options outputs wrong after reset");

    chk_stop_illegal: assert property (
        (stop_exec && !stop_mode_allow && !$past(wr_opt) && !wr_opt)
        |=> (illegal_opcode_reset && !stop_enter))
        else $error("stop with stop disallowed was not illegal");

    chk_clkout_off_low: assert property (
        (!pin_en)[*2] |-> (!port_c_pin_two && !port_c_pin_two_oe))
        else $error("clock output active while disabled");

    chk_clkout_zero_low: assert property (
        (pin_en && divide == 3'h0)[*3] |-> (port_c_pin_two_oe && !port_c_pin_two))
        else $error("clock output not held low with zero divide");

    chk_id_constant: assert property (
        reg_rd && (sel_idh || sel_idl) |=> (reg_rdata ==
        ($past(sel_idh) ? {ID_HIGH_RSVD, PART_ID[11:8]} : PART_ID[7:0])))
        else $error("part id read value wrong");

endmodule // sodr_regs

`default_nettype wire

// ==== bench/sodr_dbg_host.sv ====
// Purpose: behavioural serial background debug host, reduced to its register writes
// Assumes: one write per call, launched after an optional idle gap
// Notes:   released data lines show the inverse of the last byte
`default_nettype none

module sodr_dbg_host
    import sodr_pkg::*;
(
    // clock
    input  wire logic                 core_clk,
    // debug write path
    output var  logic                 host_wr,
    output var  sodr_pkg::sodr_addr_t host_addr,
    output var  sodr_pkg::sodr_byte_t host_wdata
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        host_wr    = 1'b0;
        host_addr  = 3'h0;
        host_wdata = 8'h5a;
    end

    // ------------------------------------------------------------------
    // background memory write command, gap sets a slow or prompt host
    // ------------------------------------------------------------------
    task automatic write_byte(input sodr_addr_t a, input sodr_byte_t d, input int gap);
        repeat (gap) @(posedge core_clk);
        @(posedge core_clk);
        host_addr  <= a;
        host_wdata <= d;
        host_wr    <= 1'b1;
        @(posedge core_clk);
        host_wr    <= 1'b0;
        host_wdata <= ~d;
    endtask

endmodule // sodr_dbg_host

`default_nettype wire

// ==== bench/sodr_regs_tb_top.sv ====
// Purpose: self-checking bench of the system options and debug reset bank
// Assumes: 10 MHz core_clk, synchronous active-low reset
// Notes:   program accesses come from the bench, debug writes from the host model
`default_nettype none

`define CHK(g, e) chk(8'(g), 8'(e))

module sodr_regs_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import sodr_pkg::*;

    localparam logic [11:0] ID_VAL  = 12'h5a3; // arbitrary value
    localparam logic [3:0]  ID_RSVD = 4'h0;

    logic       core_clk = 1'b0;
    logic       rst_n    = 1'b0;
    sodr_addr_t cpu_addr = 3'h0;
    logic       cpu_wr   = 1'b0;
    logic       reg_rd   = 1'b0;
    sodr_byte_t cpu_wdata = 8'h00;
    logic       stop_exec = 1'b0;
    logic       host_wr;
    sodr_addr_t host_addr;
    sodr_byte_t host_wdata;
    sodr_byte_t reg_rdata;
    logic       mcu_reset_req, reset_cause_flags_clear, watchdog_enable, watchdog_long_timeout;
    logic       stop_mode_allow, stop_enter, illegal_opcode_reset, port_c_pin_two, pin_oe;
    int         n_errors = 0;
    int         total_checks = 0;
    int         cycles = 0;
    sodr_byte_t d;

    wire sodr_addr_t mux_addr  = host_wr ? host_addr : cpu_addr;
    wire sodr_byte_t mux_wdata = host_wr ? host_wdata : cpu_wdata;
    wire logic       mux_wr    = host_wr | cpu_wr;

    always #50 core_clk = ~core_clk;

    sodr_dbg_host HOST (.core_clk(core_clk), .host_wr(host_wr), .host_addr(host_addr),
                        .host_wdata(host_wdata));

    sodr_regs #(.PART_ID(ID_VAL), .ID_HIGH_RSVD(ID_RSVD)) DUT
    (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(mux_addr), .reg_wr(mux_wr),
        .reg_rd(reg_rd), .reg_from_debug(host_wr), .reg_wdata(mux_wdata),
        .reg_rdata(reg_rdata), .mcu_reset_req(mcu_reset_req),
        .reset_cause_flags_clear(reset_cause_flags_clear),
        .watchdog_enable(watchdog_enable), .watchdog_long_timeout(watchdog_long_timeout),
        .stop_mode_allow(stop_mode_allow), .stop_exec(stop_exec), .stop_enter(stop_enter),
        .illegal_opcode_reset(illegal_opcode_reset), .port_c_pin_two(port_c_pin_two),
        .port_c_pin_two_oe(pin_oe)
    );

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic do_reset(input int n);
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (n) @(posedge core_clk);
        rst_n <= 1'b1;
    endtask

    task automatic bus_wr(input sodr_addr_t a, input sodr_byte_t v);
        @(posedge core_clk);
        cpu_addr  <= a;
        cpu_wdata <= v;
        cpu_wr    <= 1'b1;
        @(posedge core_clk);
        cpu_wr    <= 1'b0;
    endtask

    task automatic bus_rd(input sodr_addr_t a, output sodr_byte_t v);
        @(posedge core_clk);
        cpu_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // counts reset pulses over six cycles, flags clear must track the request
    task automatic count_reset(output int n);
        n = 0;
        #1;
        repeat (6)
        begin
            n += int'(mcu_reset_req);
            `CHK(reset_cause_flags_clear, mcu_reset_req);
            cyc(1);
        end
    endtask

    task automatic stop_pulse(input logic allowed);
        int ne;
        int ni;
        ne = 0;
        ni = 0;
        @(posedge core_clk);
        stop_exec <= 1'b1;
        @(posedge core_clk);
        stop_exec <= 1'b0;
        #1;
        repeat (4)
        begin
            ne += int'(stop_enter);
            ni += int'(illegal_opcode_reset);
            cyc(1);
        end
        `CHK(ne, allowed);
        `CHK(ni, !allowed);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_defaults();
        cyc(1);
        `CHK(watchdog_enable, 1);
        `CHK(watchdog_long_timeout, 1);
        `CHK(stop_mode_allow, 0);
        `CHK(pin_oe, 0);
        bus_rd(ADDR_SYSTEM_OPTIONS_ONCE, d); `CHK(d, 8'hc0);
        bus_rd(ADDR_DEBUG_FORCE_RESET, d); `CHK(d, 8'h00);
        bus_rd(3'h6, d); `CHK(d, 8'h00);
        stop_pulse(1'b0);
        $display("test defaults done");
    endtask

    task automatic t_options_once();
        bus_wr(ADDR_SYSTEM_OPTIONS_ONCE, 8'hff);
        bus_wr(ADDR_SYSTEM_OPTIONS_ONCE, 8'h00);
        bus_rd(ADDR_SYSTEM_OPTIONS_ONCE, d); `CHK(d, 8'hf3);
        `CHK(stop_mode_allow, 1);
        stop_pulse(1'b1);
        do_reset(2);
        bus_rd(ADDR_SYSTEM_OPTIONS_ONCE, d); `CHK(d, 8'hc0);
        bus_wr(ADDR_SYSTEM_OPTIONS_ONCE, 8'h0c);
        cyc(2);
        `CHK(watchdog_enable, 0);
        `CHK(watchdog_long_timeout, 0);
        bus_wr(ADDR_SYSTEM_OPTIONS_ONCE, 8'hc0);
        bus_rd(ADDR_SYSTEM_OPTIONS_ONCE, d); `CHK(d, 8'h00);
        $display("test options done");
    endtask

    task automatic t_force_reset();
        int n;
        bus_wr(ADDR_DEBUG_FORCE_RESET, 8'hff);
        count_reset(n); `CHK(n, 0);
        HOST.write_byte(ADDR_DEBUG_FORCE_RESET, 8'hfe, 3);
        count_reset(n); `CHK(n, 0);
        HOST.write_byte(ADDR_DEBUG_FORCE_RESET, 8'h01, 0);
        count_reset(n); `CHK(n, 1);
        HOST.write_byte(ADDR_DEBUG_FORCE_RESET, 8'hff, 5);
        count_reset(n); `CHK(n, 1);
        bus_rd(ADDR_DEBUG_FORCE_RESET, d); `CHK(d, 8'h00);
        $display("test force reset done");
    endtask

    task automatic t_clock_out();
        int per;
        int k;
        for (int dv = 1; dv < 8; dv++)
        begin
            bus_wr(ADDR_CLOCK_OUTPUT_CONTROL, 8'(8'h10 | dv));
            cyc(6);
            `CHK(pin_oe, 1);
            k = 0;
            while (!(port_c_pin_two === 1'b0) && k < 40) begin cyc(1); k++; end
            while (!(port_c_pin_two === 1'b1) && k < 40) begin cyc(1); k++; end
            per = 0;
            while (!(port_c_pin_two === 1'b0) && per < 40) begin cyc(1); per++; end
            while (!(port_c_pin_two === 1'b1) && per < 40) begin cyc(1); per++; end
            `CHK(per, 2 * dv);
        end
        bus_wr(ADDR_CLOCK_OUTPUT_CONTROL, 8'h10);
        cyc(4);
        k = 0;
        repeat (20) begin k += int'(port_c_pin_two !== 1'b0); cyc(1); end
        `CHK(k, 0);
        `CHK(pin_oe, 1);
        bus_wr(ADDR_CLOCK_OUTPUT_CONTROL, 8'hff);
        bus_rd(ADDR_CLOCK_OUTPUT_CONTROL, d); `CHK(d, 8'h17);
        bus_wr(ADDR_CLOCK_OUTPUT_CONTROL, 8'h03);
        cyc(4);
        `CHK(pin_oe, 0);
        `CHK(port_c_pin_two, 0);
        $display("test clock output done");
    endtask

    task automatic t_part_id();
        bus_wr(ADDR_PART_ID_HIGH, 8'hff);
        HOST.write_byte(ADDR_PART_ID_LOW, 8'h00, 1);
        bus_wr(ADDR_PART_ID_LOW, 8'hff);
        bus_rd(ADDR_PART_ID_HIGH, d); `CHK(d, {ID_RSVD, ID_VAL[11:8]});
        bus_rd(ADDR_PART_ID_LOW, d); `CHK(d, ID_VAL[7:0]);
        do_reset(3);
        bus_rd(ADDR_PART_ID_HIGH, d); `CHK(d[3:0], ID_VAL[11:8]);
        bus_rd(ADDR_PART_ID_LOW, d); `CHK(d, ID_VAL[7:0]);
        $display("test part id done");
    endtask

    // ------------------------------------------------------------------
    // run and hang guard
    // ------------------------------------------------------------------
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles >= 20000)
        begin
            n_errors++;
            stop_test();
        end
    end

    initial
    begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        t_defaults();
        t_options_once();
        t_force_reset();
        t_clock_out();
        t_part_id();
        stop_test();
    end

endmodule // sodr_regs_tb_top

`default_nettype wire
